/* aif_top.sv */
/*
 * analog input feature/status block: sample post-processing, status
 * byte, register access and gain/offset adjustment by control byte.
 * assumes one sample at a time from the converter, one control byte
 * request at a time from the coupler side, all synchronous to clk.
 */
// Operation
// - below lower range limit: set under-range bit; with feature bit 8, output the minimum
// - above upper range limit: set over-range bit; with feature bit 8, output the maximum
// - converter offset loads from adc preset, default 0x1000
// - feature bit 0 enables user scaling, default off
// - feature bit 1 enables manufacturer scaling, default on
// - feature bit 2 enables watchdog, on after reset
// - feature bit 3 gives sign-magnitude output, minus one is 0x8001
// - feature bit 4 selects alternate format with status in low three bits
// - alternate format: value in bits 3..15, bit 15 sign
// - alternate format: bit 0 overflow, bit 1 error, bit 2 don't care
// - feature bit 8 clamps out-of-range values to the range limits
// - feature bit 9 compares value with first limit
// - feature bit 11 passes values through second-order FIR filter
// - user scaling: signed 16-bit offset, signed gain weighted 2^-8
// - status bits 2/3 report first limit: off, above, below, equal
// - status bits 4/5 report second limit with same encoding
// - status bit 7 reads 0, bit 6 flags general error
// - status bit 1 over-range, bit 0 under-range
// - control bit 7 selects register access, else process data
// - unlock word 0x1235; any other value locks
// - bit 7 clear, bit 6 set: adjust; bit 4 gain, bit 3 offset
// - adjusted values commit to storage only when unlock word cleared
`timescale 1ns/1ps
`default_nettype none
`include "aif_defines.svh"

module aif_top #(
    parameter int SLOW_CYC = `AIF_SLOW_MS * `AIF_CLK_KHZ,
    parameter int FAST_CYC = `AIF_FAST_MS * `AIF_CLK_KHZ,
    parameter int WDT_CYC = `AIF_WDT_MS * `AIF_CLK_KHZ,
    parameter int FIR_C0 = 128,
    parameter int FIR_C1 = 64,
    parameter int FIR_C2 = 64
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // converter samples
    input wire logic smp_valid,
    input wire aif_pkg::aif_smp_t smp,
    // control byte requests
    input wire logic req_valid,
    input wire aif_pkg::aif_req_t req,
    // status byte answers
    output logic rsp_valid,
    output aif_pkg::aif_rsp_t rsp,
    // processed values
    output logic pd_valid,
    output logic [1:0] pd_chan,
    output logic [15:0] pd_value,
    output logic [7:0] pd_status,
    // storage commit strobe
    output logic nv_commit
);
    import aif_pkg::*;

    // =====================================================
    // state
    aif_state_t s_ff, nxt_s;
    int x, h0, lim, period;
    logic ovr, und;
    logic [15:0] v, rd;
    logic [5:0] adr;
    logic [7:0] st;

    // =====================================================
    // next state
    always_comb begin
        x = 0;
        h0 = 0;
        lim = 0;
        period = 0;
        ovr = 1'b0;
        und = 1'b0;
        v = 16'h0000;
        rd = 16'h0000;
        st = 8'h00;
        adr = req.ctrl[5:0];
        nxt_s = s_ff;
        nxt_s.rsp_valid = 1'b0;
        nxt_s.pd_valid = 1'b0;
        nxt_s.nv_commit = 1'b0;

        if (req_valid) begin
            nxt_s.wdt_cnt = 24'h00_0000;
            nxt_s.wdt_err = 1'b0;
        end else if (!s_ff.feat[`AIF_F_WDT]) begin
            nxt_s.wdt_cnt = 24'h00_0000;
            nxt_s.wdt_err = 1'b0;
        end else if (int'(s_ff.wdt_cnt) >= WDT_CYC - 1) begin
            nxt_s.wdt_err = 1'b1;
        end else begin
            nxt_s.wdt_cnt = s_ff.wdt_cnt + 24'h00_0001;
        end

        // sample processing chain
        if (smp_valid) begin
            nxt_s.raw = {4'h0, smp.raw};
            x = int'(smp.raw) + int'(s_ff.conv_off) - int'(`AIF_RST_PRESET);
            if (s_ff.feat[`AIF_F_MAKER]) begin
                x = ((x * int'($signed(s_ff.mk_gain))) >>> `AIF_MK_SHIFT)
                    + int'($signed(s_ff.mk_off));
            end
            und = x < int'($signed(s_ff.lo_lim));
            ovr = x > int'($signed(s_ff.up_lim));
            if (s_ff.feat[`AIF_F_CLAMP] && ovr) begin
                x = int'($signed(s_ff.up_lim));
            end
            if (s_ff.feat[`AIF_F_CLAMP] && und) begin
                x = int'($signed(s_ff.lo_lim));
            end
            h0 = x;
            if (s_ff.feat[`AIF_F_FIR]) begin
                x = (FIR_C0 * x + FIR_C1 * int'($signed(s_ff.hist[smp.chan][0]))
                    + FIR_C2 * int'($signed(s_ff.hist[smp.chan][1])))
                    >>> `AIF_FIR_SHIFT;
            end
            nxt_s.hist[smp.chan][1] = s_ff.hist[smp.chan][0];
            nxt_s.hist[smp.chan][0] = h0[15:0];
            if (s_ff.feat[`AIF_F_USER]) begin
                x = ((x * int'($signed(s_ff.u_gain))) >>> `AIF_U_SHIFT)
                    + int'($signed(s_ff.u_off));
            end
            // saturate to 16-bit signed
            if (x > 32767) begin
                x = 32767;
            end else if (x < -32767) begin
                x = -32767;
            end
            lim = int'($signed(s_ff.lim1));
            if (s_ff.feat[`AIF_F_LIM1]) begin
                st[2] = x >= lim;
                st[3] = x <= lim;
            end
            lim = int'($signed(s_ff.lim2));
            if (s_ff.feat[`AIF_F_LIM2]) begin
                st[4] = x >= lim;
                st[5] = x <= lim;
            end
            // error and range bits, bit 7 zero
            st[6] = s_ff.wdt_err;
            st[1] = ovr;
            st[0] = und;
            v = x[15:0];
            if (s_ff.feat[`AIF_F_SMAG] && x < 0) begin
                h0 = -x;
                v = {1'b1, h0[14:0]};
            end
            if (s_ff.feat[`AIF_F_ALT]) begin
                v = {v[15], v[11:0], 1'b0, s_ff.wdt_err, ovr};
            end
            nxt_s.pv[smp.chan] = v;
            nxt_s.st[smp.chan] = st;
            nxt_s.pd_valid = 1'b1;
            nxt_s.pd_chan = smp.chan;
            nxt_s.out_value = v;
            nxt_s.out_status = st;
        end

        // register read mux
        case (adr)
            `AIF_R_RAW: rd = s_ff.raw;
            `AIF_R_DIAG: rd = {8'h00, s_ff.st[req.chan]};
            `AIF_R_MK_OFF: rd = s_ff.mk_off;
            `AIF_R_MK_GAIN: rd = s_ff.mk_gain;
            `AIF_R_UP_LIM: rd = s_ff.up_lim;
            `AIF_R_LO_LIM: rd = s_ff.lo_lim;
            `AIF_R_PRESET: rd = s_ff.preset;
            `AIF_R_UNLOCK: rd = s_ff.unlocked ? `AIF_UNLOCK_CODE : 16'h0000;
            `AIF_R_FEAT: rd = s_ff.feat;
            `AIF_R_U_OFF: rd = s_ff.u_off;
            `AIF_R_U_GAIN: rd = s_ff.u_gain;
            `AIF_R_LIM1: rd = s_ff.lim1;
            `AIF_R_LIM2: rd = s_ff.lim2;
            default: rd = 16'h0000;
        endcase

        if (req_valid && req.ctrl[`AIF_C_REG]) begin
            nxt_s.adj = ADJ_IDLE;
            nxt_s.rsp_valid = 1'b1;
            nxt_s.rsp.stat = {2'b10, adr};
            nxt_s.rsp.data = req.ctrl[`AIF_C_WR] ? 16'h0000 : rd;
            if (req.ctrl[`AIF_C_WR] && adr == `AIF_R_UNLOCK) begin
                nxt_s.unlocked = req.data == `AIF_UNLOCK_CODE;
                if (req.data != `AIF_UNLOCK_CODE && s_ff.dirty) begin
                    nxt_s.nv_commit = 1'b1;
                    nxt_s.dirty = 1'b0;
                end
            end else if (req.ctrl[`AIF_C_WR] && s_ff.unlocked) begin
                case (adr)
                    `AIF_R_MK_OFF: nxt_s.mk_off = req.data;
                    `AIF_R_MK_GAIN: nxt_s.mk_gain = req.data;
                    `AIF_R_UP_LIM: nxt_s.up_lim = req.data;
                    `AIF_R_LO_LIM: nxt_s.lo_lim = req.data;
                    `AIF_R_PRESET: begin
                        nxt_s.preset = req.data;
                        nxt_s.conv_off = req.data;
                    end
                    `AIF_R_FEAT: nxt_s.feat = req.data;
                    `AIF_R_U_OFF: nxt_s.u_off = req.data;
                    `AIF_R_U_GAIN: nxt_s.u_gain = req.data;
                    `AIF_R_LIM1: nxt_s.lim1 = req.data;
                    `AIF_R_LIM2: nxt_s.lim2 = req.data;
                    default: nxt_s.rsp.stat = {2'b10, adr};
                endcase
            end
        end else if (req_valid) begin
            nxt_s.rsp_valid = 1'b1;
            nxt_s.rsp.stat = s_ff.st[req.chan];
            nxt_s.rsp.data = s_ff.pv[req.chan];
            nxt_s.up = req.ctrl[`AIF_C_UP];
            nxt_s.dn = req.ctrl[`AIF_C_DN];
            nxt_s.fast = req.ctrl[`AIF_C_FAST];
            if (!req.ctrl[`AIF_C_WR] || !s_ff.unlocked) begin
                nxt_s.adj = ADJ_IDLE;
            end else if (req.ctrl[`AIF_C_GAIN]) begin
                nxt_s.adj = ADJ_GAIN;
            end else if (req.ctrl[`AIF_C_OFF]) begin
                nxt_s.adj = ADJ_OFFSET;
            end else begin
                nxt_s.adj = ADJ_IDLE;
            end
            if (nxt_s.adj != s_ff.adj) begin
                nxt_s.step_cnt = 24'h00_0000;
            end
        end

        period = s_ff.fast ? FAST_CYC : SLOW_CYC;
        case (s_ff.adj)
            ADJ_GAIN, ADJ_OFFSET: begin
                if (s_ff.up == s_ff.dn) begin
                    nxt_s.step_cnt = 24'h00_0000;
                end else if (int'(s_ff.step_cnt) >= period - 1) begin
                    nxt_s.step_cnt = 24'h00_0000;
                    nxt_s.dirty = 1'b1;
                    if (s_ff.adj == ADJ_GAIN) begin
                        nxt_s.u_gain = s_ff.up ? s_ff.u_gain + 16'h0001
                                               : s_ff.u_gain - 16'h0001;
                    end else begin
                        nxt_s.u_off = s_ff.up ? s_ff.u_off + 16'h0001
                                              : s_ff.u_off - 16'h0001;
                    end
                end else if (nxt_s.adj == s_ff.adj) begin
                    nxt_s.step_cnt = s_ff.step_cnt + 24'h00_0001;
                end
            end
            default: nxt_s.step_cnt = 24'h00_0000;
        endcase
    end

    // =====================================================
    // state register with synchronous reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_ff <= '0;
            s_ff.mk_off <= `AIF_RST_MK_OFF;
            s_ff.mk_gain <= `AIF_RST_MK_GAIN;
            s_ff.up_lim <= `AIF_RST_UP_LIM;
            s_ff.lo_lim <= `AIF_RST_LO_LIM;
            s_ff.preset <= `AIF_RST_PRESET;
            s_ff.conv_off <= `AIF_RST_PRESET;
            s_ff.feat <= `AIF_RST_FEAT;
            s_ff.u_off <= `AIF_RST_U_OFF;
            s_ff.u_gain <= `AIF_RST_U_GAIN;
            s_ff.lim1 <= `AIF_RST_LIM;
            s_ff.lim2 <= `AIF_RST_LIM;
            s_ff.adj <= ADJ_IDLE;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from the state register
    assign rsp_valid = s_ff.rsp_valid;
    assign rsp = s_ff.rsp;
    assign pd_valid = s_ff.pd_valid;
    assign pd_chan = s_ff.pd_chan;
    assign pd_value = s_ff.out_value;
    assign pd_status = s_ff.out_status;
    assign nv_commit = s_ff.nv_commit;
endmodule // aif_top
`default_nettype wire

/* aif_defines.svh */
/*
 * register indices, reset values, field positions and timing counts
 * for the analog input feature/status block; included by bare name
 */
`ifndef AIF_DEFINES_SVH
`define AIF_DEFINES_SVH
// =====================================================
// register indices (control byte bits 5..0)
`define AIF_R_RAW 6'h00
`define AIF_R_DIAG 6'h06
`define AIF_R_MK_OFF 6'h13
`define AIF_R_MK_GAIN 6'h14
`define AIF_R_UP_LIM 6'h15
`define AIF_R_LO_LIM 6'h16
`define AIF_R_PRESET 6'h17
`define AIF_R_UNLOCK 6'h1F
`define AIF_R_FEAT 6'h20
`define AIF_R_U_OFF 6'h21
`define AIF_R_U_GAIN 6'h22
`define AIF_R_LIM1 6'h23
`define AIF_R_LIM2 6'h24
// =====================================================
// reset values
`define AIF_RST_MK_OFF 16'h0000
`define AIF_RST_MK_GAIN 16'h2002
`define AIF_RST_UP_LIM 16'h0FFF
`define AIF_RST_LO_LIM 16'h0000
`define AIF_RST_PRESET 16'h1000
`define AIF_RST_FEAT 16'h1106
`define AIF_RST_U_OFF 16'h0000
`define AIF_RST_U_GAIN 16'h0100
`define AIF_RST_LIM 16'h0000
`define AIF_UNLOCK_CODE 16'h1235
// =====================================================
// feature bits
`define AIF_F_USER 0
`define AIF_F_MAKER 1
`define AIF_F_WDT 2
`define AIF_F_SMAG 3
`define AIF_F_ALT 4
`define AIF_F_CLAMP 8
`define AIF_F_LIM1 9
`define AIF_F_LIM2 10
`define AIF_F_FIR 11
// control byte bits
`define AIF_C_REG 7
`define AIF_C_WR 6
`define AIF_C_GAIN 4
`define AIF_C_OFF 3
`define AIF_C_FAST 2
`define AIF_C_UP 1
`define AIF_C_DN 0
// =====================================================
// timing: times in ms, clock in kHz
`define AIF_CLK_KHZ 10000
`define AIF_SLOW_MS 1000
`define AIF_FAST_MS 50
`define AIF_WDT_MS 100
`define AIF_MK_SHIFT 10
`define AIF_U_SHIFT 8
`define AIF_FIR_SHIFT 8
`endif

/* aif_pkg.sv */
/*
 * types of the analog input feature/status block
 * assumes aif_defines.svh alongside
 */
package aif_pkg;
    typedef enum logic [1:0] {ADJ_IDLE, ADJ_GAIN, ADJ_OFFSET} aif_adj_t;
    // one converted sample from the converter
    typedef struct packed {
        logic [1:0] chan;
        logic [11:0] raw;
    } aif_smp_t;
    // one control byte with its data word
    typedef struct packed {
        logic [1:0] chan;
        logic [7:0] ctrl;
        logic [15:0] data;
    } aif_req_t;
    // status byte with its data word
    typedef struct packed {
        logic [7:0] stat;
        logic [15:0] data;
    } aif_rsp_t;
    typedef struct packed {
        logic [15:0] raw, conv_off, mk_off, mk_gain, up_lim, lo_lim;
        logic [15:0] preset, feat, u_off, u_gain, lim1, lim2;
        logic unlocked, dirty, wdt_err, nv_commit, rsp_valid, pd_valid;
        logic [23:0] wdt_cnt, step_cnt;
        aif_adj_t adj;
        logic up, dn, fast;
        logic [3:0][15:0] pv;
        logic [3:0][7:0] st;
        logic [3:0][1:0][15:0] hist;
        logic [1:0] pd_chan;
        logic [15:0] out_value;
        logic [7:0] out_status;
        aif_rsp_t rsp;
    } aif_state_t;
endpackage

/* aif_coupler.sv */
/* coupler-side model: issues one control byte request at a time
   assumes aif_pkg compiled first; its task is called by the bench */
`timescale 1ns/1ps
`default_nettype none
module aif_coupler (
    // clock
    input wire logic clk,
    // request side
    output logic req_valid,
    output aif_pkg::aif_req_t req
);
    import aif_pkg::*;
    // ====================
    // idle lines at start
    initial begin
        req_valid = 1'b0;
        req = '0;
    end
    // raise after a falling edge, hold over one rising edge, then release
    // control byte picks mode, unlock word travels as data
    task automatic send(input logic [7:0] ctl, input logic [1:0] c, input logic [15:0] d);
        @(negedge clk);
        req_valid = 1'b1;
        req = '{chan: c, ctrl: ctl, data: d};
        @(negedge clk);
        req_valid = 1'b0;
        req = ~req; // released lines show no stale value
    endtask
endmodule // aif_coupler
`default_nettype wire

/* aif_top_chk.sv */
/* assertions on the ports of aif_top
   assumes aif_pkg compiled first; bound to every aif_top */
`timescale 1ns/1ps
`default_nettype none
module aif_top_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // samples and requests
    input wire logic smp_valid,
    input wire aif_pkg::aif_smp_t smp,
    input wire logic req_valid,
    input wire aif_pkg::aif_req_t req,
    // answers and results
    input wire logic rsp_valid,
    input wire aif_pkg::aif_rsp_t rsp,
    input wire logic pd_valid,
    input wire logic [1:0] pd_chan,
    input wire logic [15:0] pd_value,
    input wire logic [7:0] pd_status,
    input wire logic nv_commit
);
    import aif_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ====================
    // answer and result timing
    rsp_follow_a: assert property (req_valid |=> rsp_valid)
        else $error("no answer one cycle after a request");
    rsp_alone_a: assert property (!req_valid |=> !rsp_valid)
        else $error("answer without a request");
    pd_follow_a: assert property (smp_valid |=> pd_valid && pd_chan == $past(smp.chan))
        else $error("processed sample missing or on the wrong channel");
    // ====================
    // status and answer contents
    stat_top_a: assert property (pd_valid |-> !pd_status[7])
        else $error("status bit 7 set");
    reg_echo_a: assert property (req_valid && req.ctrl[7] |=>
        rsp.stat == {2'b10, $past(req.ctrl[5:0])})
        else $error("register answer does not echo the index");
    pd_mode_a: assert property (req_valid && !req.ctrl[7] |=> !rsp.stat[7])
        else $error("process data answer with bit 7 set");
    wr_data_a: assert property (req_valid && req.ctrl[7:6] == 2'b11 |=> rsp.data == 16'h0000)
        else $error("write answer carries data");
    unlock_rd_a: assert property (req_valid && req.ctrl == 8'h9F |=>
        rsp.data == 16'h0000 || rsp.data == 16'h1235)
        else $error("unlock word reads a stray value");
    // ====================
    // storage commit
    commit_src_a: assert property (nv_commit |-> $past(req_valid)
        && $past(req.ctrl) == 8'hDF && $past(req.data) != 16'h1235)
        else $error("commit without clearing the unlock word");
    commit_once_a: assert property (nv_commit |=> !nv_commit)
        else $error("commit strobe longer than one cycle");
endmodule // aif_top_chk
bind aif_top aif_top_chk chk (.clk(clk), .rst_b(rst_b), .smp_valid(smp_valid), .smp(smp),
    .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .pd_valid(pd_valid),
    .pd_chan(pd_chan), .pd_value(pd_value), .pd_status(pd_status), .nv_commit(nv_commit));
`default_nettype wire

/* analog_input_feature_status_test.sv */
/* self-checking bench for aif_top
   assumes aif_pkg, aif_coupler and the checker compiled before it */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module analog_input_feature_status_test;
    import aif_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, smp_valid = 1'b0, wd = 1'b0;
    aif_smp_t smp = '0;
    logic req_valid, rsp_valid, pd_valid, nv_commit;
    aif_req_t req;
    aif_rsp_t rsp;
    logic [1:0] pd_chan, c;
    logic [15:0] pd_value, feat, mk_off, u_off, u_gain, lim1, lim2;
    logic [7:0] pd_status;
    logic [47:0] rq[$], e;
    logic [23:0] pq[$], f, last[4] = '{default: 24'h00_0000};
    int err_count, n_tests, n_commit, h0[4], h1[4];
    logic [15:0] modes[7] = '{16'h1106, 16'h0000, 16'h0103, 16'h0109, 16'h0111,
        16'h0600, 16'h0902};
    logic [11:0] raws[4] = '{12'h000, 12'h800, 12'h010, 12'hFFF};
    logic [5:0] ri[12] = '{6'h17, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h1F, 6'h13, 6'h14,
        6'h15, 6'h16, 6'h30};
    logic [15:0] rv[12] = '{16'h1000, 16'h1106, 16'h0000, 16'h0100, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h2002, 16'h0FFF, 16'h0000, 16'h0000};
    // ====================
    // clock, design and coupler
    always #50 clk = ~clk;
    aif_top #(.SLOW_CYC(20), .FAST_CYC(5), .WDT_CYC(50)) uut (.clk(clk), .rst_b(rst_b),
        .smp_valid(smp_valid), .smp(smp), .req_valid(req_valid), .req(req),
        .rsp_valid(rsp_valid), .rsp(rsp), .pd_valid(pd_valid), .pd_chan(pd_chan),
        .pd_value(pd_value), .pd_status(pd_status), .nv_commit(nv_commit));
    aif_coupler cp (.clk(clk), .req_valid(req_valid), .req(req));
    // ====================
    // expected processed value and status byte
    function automatic logic [23:0] model(input logic [11:0] r, input logic [1:0] ch);
        int x, y;
        logic [7:0] s;
        logic [15:0] v;
        x = r;
        s = 8'h00;
        if (feat[1]) x = ((x * 8194) >>> 10) + $signed(mk_off);
        s[0] = x < 0;
        s[1] = x > 4095;
        if (feat[8]) x = s[0] ? 0 : (s[1] ? 4095 : x);
        y = x;
        if (feat[11]) x = (128 * x + 64 * h0[ch] + 64 * h1[ch]) >>> 8;
        h1[ch] = h0[ch];
        h0[ch] = y;
        if (feat[0]) x = ((x * $signed(u_gain)) >>> 8) + $signed(u_off);
        x = x > 32767 ? 32767 : (x < -32767 ? -32767 : x);
        if (feat[9]) s[3:2] = {x <= $signed(lim1), x >= $signed(lim1)};
        if (feat[10]) s[5:4] = {x <= $signed(lim2), x >= $signed(lim2)};
        s[6] = wd;
        v = x[15:0];
        if (feat[3] && x < 0) v = {1'b1, 15'(-x)};
        if (feat[4]) v = {v[15], v[11:0], 1'b0, wd, s[1]};
        return {s, v};
    endfunction
    // ====================
    // request and sample tasks, each noting its expectation
    task automatic xfer(input logic [7:0] t, input logic [1:0] ch, input logic [15:0] d,
        input logic [23:0] m, input logic [23:0] x);
        rq.push_back({m, x & m});
        cp.send(t, ch, d);
    endtask
    task automatic wr(input logic [5:0] i, input logic [15:0] v);
        xfer({2'b11, i}, 2'd0, v, 24'hFF_FFFF, {2'b10, i, 16'h0000});
    endtask
    task automatic rd(input logic [5:0] i, input logic [15:0] v);
        xfer({2'b10, i}, 2'd0, 16'($urandom), 24'hFF_FFFF, {2'b10, i, v});
    endtask
    task automatic pdq(input logic [1:0] ch);
        xfer(8'h00, ch, 16'($urandom), 24'hFF_FFFF, last[ch]);
    endtask
    task automatic go(input logic [11:0] r, input logic [1:0] ch);
        @(negedge clk);
        smp_valid = 1'b1;
        smp = '{chan: ch, raw: r};
        last[ch] = model(r, ch);
        pq.push_back(last[ch]);
        @(negedge clk);
        smp_valid = 1'b0;
        smp = ~smp;
    endtask
    task automatic wrap_up;
        $display("counts: tests=%0d errors=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // compare answers and results with the oldest note
    always @(negedge clk) begin
        if (rsp_valid === 1'b1) begin
            e = rq.pop_front();
            `CHK(rsp & e[47:24], e[23:0])
        end
        if (pd_valid === 1'b1) begin
            f = pq.pop_front();
            `CHK({pd_status, pd_value}, f)
        end
        if (nv_commit === 1'b1) n_commit++;
    end
    // hang guard
    initial begin
        #2_000_000;
        err_count++;
        wrap_up();
    end
    // main sequence
    initial begin
        void'($urandom(68));
        {feat, mk_off, u_off, u_gain, lim1, lim2} = {16'h1106, 32'h0, 16'h0100, 32'h0};
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        for (int i = 0; i < 12; i++) rd(ri[i], rv[i]);
        $display("test reset values done");
        wr(6'h20, 16'h0000);
        xfer(8'h56, 2'd0, 16'h0000, 24'hFF_FFFF, last[0]);
        repeat (30) @(negedge clk);
        pdq(2'd0);
        rd(6'h20, 16'h1106);
        rd(6'h22, 16'h0100);
        wr(6'h1F, 16'h1235);
        rd(6'h1F, 16'h1235);
        $display("test lock done");
        {mk_off, u_off, u_gain, lim1, lim2} = {16'hFF00, 16'hF800, 16'h0180, 32'h0800_0400};
        wr(6'h13, mk_off);
        wr(6'h21, u_off);
        wr(6'h22, u_gain);
        wr(6'h23, lim1);
        wr(6'h24, lim2);
        for (int i = 0; i < 7; i++) begin
            feat = modes[i];
            wr(6'h20, feat);
            for (int k = 0; k < 4; k++) begin
                c = feat[11] ? 2'd3 : 2'(k % 3);
                if (k == 0 && feat[2]) begin
                    repeat (80) @(negedge clk);
                    wd = 1'b1;
                end
                go(k == 0 ? 12'($urandom) : raws[k], c);
                pdq(c);
                wd = 1'b0;
            end
        end
        $display("test features done");
        rd(6'h06, {8'h00, last[0][23:16]});
        rd(6'h00, 16'h0FFF);
        xfer(8'h56, 2'd0, 16'($urandom), 24'hFF_FFFF, last[0]);
        repeat (46) @(negedge clk);
        pdq(2'd0);
        xfer(8'hA2, 2'd0, 16'h0000, 24'hFF_FFFC, {8'hA2, 16'h0188});
        xfer(8'h49, 2'd0, 16'($urandom), 24'hFF_FFFF, last[0]);
        repeat (46) @(negedge clk);
        pdq(2'd0);
        xfer(8'hA1, 2'd0, 16'h0000, 24'hFF_FFFC, {8'hA1, 16'hF7FC});
        `CHK(n_commit, 0)
        wr(6'h1F, 16'h0000);
        repeat (3) @(negedge clk);
        `CHK(n_commit, 1)
        $display("test adjust done");
        wrap_up();
    end
endmodule // analog_input_feature_status_test
`default_nettype wire
